/* hdl/pts_pkg.sv */
// constants and types for the pattern trigger and light-source sync block
package pts_pkg;
   // ==========================================================
   // widths and defaults
   localparam int          PTS_PAT_W        = 8;
   localparam int          PTS_PWM_W        = 8;
   localparam int          PTS_EXPO_W       = 16;
   localparam logic [7:0]  PTS_PAT_FIRST    = 8'h00;
   localparam logic [7:0]  PTS_PAT_LAST_DEF = 8'h07;
   localparam logic [15:0] PTS_EXPO_DEF     = 16'h0032;
   localparam logic [7:0]  PTS_DUTY_DEF     = 8'h80;
   localparam int          PTS_SYNC_STAGES  = 2;
   // colour lane indices
   localparam int          PTS_RED          = 0;
   localparam int          PTS_GREEN        = 1;
   localparam int          PTS_BLUE         = 2;
   localparam int          PTS_NUM_COLOURS  = 3;

   // ==========================================================
   // sequencer states
   typedef enum logic [1:0] {
      PTS_IDLE   = 2'b00,
      PTS_WAIT   = 2'b01,
      PTS_EXPOSE = 2'b10
   } pts_state_e;
endpackage

/* hdl/pts_sync2.sv */
// two-flop level synchroniser
`timescale 1ns/1ns
module pts_sync2 (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // ==========================================================
   // first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

/* hdl/pts_trigger_sync.sv */
// pattern trigger, light-source and dual-controller sync block
`timescale 1ns/1ns
module pts_trigger_sync
   import pts_pkg::*;
#(
   parameter int PAT_W  = PTS_PAT_W,
   parameter int PWM_W  = PTS_PWM_W,
   parameter int EXPO_W = PTS_EXPO_W
) (
   // clock and reset
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst,
   // configuration from the controller core
   input  wire logic                                  pattern_mode,
   input  wire logic [PAT_W-1:0]                      pattern_last,
   input  wire logic [EXPO_W-1:0]                     expose_cycles,
   input  wire logic [PTS_NUM_COLOURS-1:0]            colour_select,
   input  wire logic [PTS_NUM_COLOURS*PWM_W-1:0]      colour_duty,
   // software start and stop, one-cycle pulses
   input  wire logic                                  sw_start,
   input  wire logic                                  sw_stop,
   // trigger pins
   input  wire logic                                  pattern_advance_in,
   input  wire logic                                  pattern_run_in,
   output logic                                       exposure_active_out,
   output logic                                       first_pattern_out,
   // light-source pins
   output logic                                       red_current_pwm,
   output logic                                       green_current_pwm,
   output logic                                       blue_current_pwm,
   output logic                                       red_source_on,
   output logic                                       green_source_on,
   output logic                                       blue_source_on,
   // dual-controller pins
   input  wire logic                                  role_strap,
   input  wire logic                                  secondary_present_i,
   output logic                                       secondary_present_o,
   output logic                                       secondary_present_oe,
   input  wire logic                                  sequence_align_line_i,
   output logic                                       sequence_align_line_o,
   output logic                                       sequence_align_line_oe,
   input  wire logic                                  serial_clk,
   input  wire logic                                  serial_cs_req,
   output logic                                       secondary_port_select_n_o,
   output logic                                       secondary_port_select_n_oe,
   // status to the controller core
   output logic                                       is_primary,
   output logic                                       secondary_ready,
   output logic                                       running,
   output logic [PAT_W-1:0]                           pattern_index
);
   logic              adv_s, run_s, strap_s, pres_s, align_s, sclk_s;
   logic              adv_q, run_q, sclk_q, align_q;
   logic              adv_rise, run_rise, run_fall, align_fall;
   logic              primary_q, strap_seen_q;
   logic [PTS_SYNC_STAGES-1:0] strap_wait_q;
   logic              go, stop;
   pts_state_e        state_q;
   logic [EXPO_W-1:0] expo_cnt_q;
   logic [PAT_W-1:0]  pat_q;
   logic [PWM_W-1:0]  pwm_cnt_q;
   logic [PTS_NUM_COLOURS-1:0] pwm_q, en_q;
   logic              cs_n_q;

   // ==========================================================
   // synchronisers for every pin input except serial_cs_req
   pts_sync2 u_adv   (.clk_sys(clk_sys), .rst(rst), .async_in(pattern_advance_in),    .sync_out(adv_s));
   pts_sync2 u_run   (.clk_sys(clk_sys), .rst(rst), .async_in(pattern_run_in),        .sync_out(run_s));
   pts_sync2 u_strap (.clk_sys(clk_sys), .rst(rst), .async_in(role_strap),            .sync_out(strap_s));
   pts_sync2 u_pres  (.clk_sys(clk_sys), .rst(rst), .async_in(secondary_present_i),   .sync_out(pres_s));
   pts_sync2 u_align (.clk_sys(clk_sys), .rst(rst), .async_in(sequence_align_line_i), .sync_out(align_s));
   pts_sync2 u_sclk  (.clk_sys(clk_sys), .rst(rst), .async_in(serial_clk),            .sync_out(sclk_s));

   // edge history taken from synchronised levels only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         adv_q   <= 1'b0;
         run_q   <= 1'b0;
         sclk_q  <= 1'b0;
         align_q <= 1'b1;
      end else begin
         adv_q   <= adv_s;
         run_q   <= run_s;
         sclk_q  <= sclk_s;
         align_q <= align_s;
      end
   end

   // ==========================================================
   // role strap caught once after reset release, held for the session
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         primary_q    <= 1'b0;
         strap_seen_q <= 1'b0;
         strap_wait_q <= '0;
      end else begin
         // reset clears the strap synchroniser, so wait until both stages hold the pin
         strap_wait_q <= {strap_wait_q[PTS_SYNC_STAGES-2:0], 1'b1};
         if (strap_wait_q[PTS_SYNC_STAGES-1] && !strap_seen_q) begin
            primary_q    <= strap_s;
            strap_seen_q <= 1'b1;
         end
      end
   end

   assign is_primary      = primary_q;
   assign secondary_ready = primary_q & pres_s;

   // triggers count only on a primary in pattern mode
   assign adv_rise   = adv_s & ~adv_q & primary_q & pattern_mode;
   assign run_rise   = run_s & ~run_q & primary_q & pattern_mode;
   assign run_fall   = ~run_s & run_q & primary_q & pattern_mode;
   // a secondary follows the primary's start via the shared line
   assign align_fall = ~align_s & align_q & ~primary_q & strap_seen_q;
   assign go         = run_rise | (sw_start & pattern_mode) | align_fall;
   assign stop       = run_fall | sw_stop | ~pattern_mode;

   // ==========================================================
   // pattern sequencer; stop beats start when both arrive together
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q    <= PTS_IDLE;
         pat_q      <= PTS_PAT_FIRST[PAT_W-1:0];
         expo_cnt_q <= '0;
      end else begin
         case (state_q)
            PTS_IDLE: begin
               if (go && !stop) begin
                  pat_q      <= PTS_PAT_FIRST[PAT_W-1:0];
                  expo_cnt_q <= expose_cycles;
                  state_q    <= PTS_EXPOSE;
               end
            end
            PTS_WAIT: begin
               if (stop) begin
                  state_q <= PTS_IDLE;
               end else if (adv_rise) begin
                  pat_q      <= (pat_q == pattern_last) ? PTS_PAT_FIRST[PAT_W-1:0] : pat_q + 1'b1;
                  expo_cnt_q <= expose_cycles;
                  state_q    <= PTS_EXPOSE;
               end
            end
            PTS_EXPOSE: begin
               if (stop) begin
                  state_q <= PTS_IDLE;
               end else if (expo_cnt_q <= 1) begin
                  state_q <= PTS_WAIT;
               end else begin
                  expo_cnt_q <= expo_cnt_q - 1'b1;
               end
            end
            default: state_q <= PTS_IDLE;
         endcase
      end
   end

   assign running       = (state_q != PTS_IDLE);
   assign pattern_index = pat_q;

   // registered trigger outputs; a secondary keeps them low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         exposure_active_out <= 1'b0;
         first_pattern_out   <= 1'b0;
      end else begin
         exposure_active_out <= primary_q && state_q == PTS_EXPOSE && !stop;
         first_pattern_out   <= primary_q && running && !stop &&
                                pat_q == PTS_PAT_FIRST[PAT_W-1:0];
      end
   end

   // ==========================================================
   // shared free-running pwm counter keeps the three colours phase aligned
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwm_cnt_q <= '0;
      end else begin
         pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end
   end

   // one enable and one current pwm per colour
   genvar c;
   generate
      for (c = 0; c < PTS_NUM_COLOURS; c++) begin : g_colour
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               en_q[c]  <= 1'b0;
               pwm_q[c] <= 1'b0;
            end else begin
               en_q[c]  <= primary_q & running & colour_select[c];
               pwm_q[c] <= primary_q & running & colour_select[c] &
                           (pwm_cnt_q < colour_duty[c*PWM_W +: PWM_W]);
            end
         end
      end
   endgenerate

   assign red_source_on     = en_q[PTS_RED];
   assign green_source_on   = en_q[PTS_GREEN];
   assign blue_source_on    = en_q[PTS_BLUE];
   assign red_current_pwm   = pwm_q[PTS_RED];
   assign green_current_pwm = pwm_q[PTS_GREEN];
   assign blue_current_pwm  = pwm_q[PTS_BLUE];

   // ==========================================================
   // present line: secondary pulls high when up, primary only listens
   assign secondary_present_o  = 1'b1;
   assign secondary_present_oe = strap_seen_q & ~primary_q;

   // align line is open drain: primary pulls low while running
   assign sequence_align_line_o  = 1'b0;
   assign sequence_align_line_oe = primary_q & running;

   // select changes only on a falling serial clock edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_n_q <= 1'b1;
      end else if (~sclk_s & sclk_q) begin
         cs_n_q <= ~(serial_cs_req & primary_q & pres_s);
      end
   end

   assign secondary_port_select_n_o  = cs_n_q;
   assign secondary_port_select_n_oe = primary_q;
endmodule

/* testbench/pts_far_model.sv */
// far-side model: secondary controller lines with board resistors
`timescale 1ns/1ns
module pts_far_model (
   // secondary readiness
   input  wire logic sec_ready,
   // block pin drivers
   input  wire logic present_o,
   input  wire logic present_oe,
   input  wire logic align_o,
   input  wire logic align_oe,
   // the other controller's pull on the shared align line
   input  wire logic peer_align_low,
   // resolved line levels
   output logic      present_level,
   output logic      align_level
);
   // pulldown line; a ready secondary pulls it high
   assign present_level = sec_ready | (present_oe & present_o);
   // pullup line; any enabled driver pulls it low
   assign align_level = ~((align_oe & ~align_o) | peer_align_low);
endmodule

/* testbench/pts_trigger_sync_props.sv */
// assertion checker for the pattern trigger sync block
`timescale 1ns/1ns
module pts_trigger_sync_props
   import pts_pkg::*;
#(
   parameter int PAT_W = PTS_PAT_W
) (
   // clock and reset
   input wire logic                       clk_sys,
   input wire logic                       rst,
   // controls
   input wire logic                       sw_start,
   input wire logic                       sw_stop,
   input wire logic                       pattern_mode,
   input wire logic [PTS_NUM_COLOURS-1:0] colour_select,
   // pins and status
   input wire logic                       exposure_active_out,
   input wire logic                       first_pattern_out,
   input wire logic                       red_source_on,
   input wire logic                       green_source_on,
   input wire logic                       blue_source_on,
   input wire logic                       red_current_pwm,
   input wire logic                       is_primary,
   input wire logic                       secondary_ready,
   input wire logic                       running,
   input wire logic [PAT_W-1:0]           pattern_index,
   input wire logic                       secondary_present_oe,
   input wire logic                       sequence_align_line_oe,
   input wire logic                       secondary_port_select_n_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ==========================================================
   // sequencing
   a_reset_quiet: assert property (disable iff (1'b0) rst |=>
      !running && !exposure_active_out && !first_pattern_out)
      else $error("outputs active after reset");
   a_start_runs: assert property (is_primary && pattern_mode && sw_start && !sw_stop && !running |=> running)
      else $error("start command ignored");
   a_stop_wins: assert property (sw_stop |=> !running)
      else $error("stop command ignored");
   a_run_exposes: assert property ($rose(running) && is_primary |=> exposure_active_out)
      else $error("no exposure after start");
   a_expo_in_run: assert property (exposure_active_out |-> running || $past(running))
      else $error("exposure while stopped");
   a_first_at_zero: assert property ($rose(first_pattern_out) |-> pattern_index == '0)
      else $error("first flag on other pattern");
   a_enables_follow: assert property ($rose(running) && is_primary |=>
      {blue_source_on, green_source_on, red_source_on} == colour_select)
      else $error("enables differ from selection");
   // ==========================================================
   // roles
   a_secondary_quiet: assert property (!is_primary |->
      !(exposure_active_out | first_pattern_out | red_source_on | red_current_pwm))
      else $error("secondary drives trigger or source pins");
   a_ready_primary: assert property (secondary_ready |-> is_primary)
      else $error("ready seen on secondary");
   a_roles_oe: assert property (secondary_port_select_n_oe == is_primary &&
      !(secondary_present_oe && is_primary))
      else $error("pin enables disagree with role");
   a_align_primary: assert property (sequence_align_line_oe |-> is_primary)
      else $error("secondary pulls align line");
endmodule

/* testbench/tb_pattern_trigger_led_sync.sv */
// testbench for the pattern trigger sync block
`timescale 1ns/1ns
module tb_pattern_trigger_led_sync;
   import pts_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, pattern_mode = 1'b1, sw_start = 1'b0, sw_stop = 1'b0;
   logic adv = 1'b0, run = 1'b0, role_strap = 1'b1, sec_ready = 1'b1, serial_clk = 1'b0, cs_req = 1'b0;
   logic peer_al = 1'b0;
   logic [7:0] pattern_last = 8'h02;
   logic [15:0] expose_cycles = 16'h0005;
   logic [2:0] colour_select = 3'b111, src, pwm;
   logic [23:0] colour_duty = 24'hC08040;
   logic expo, first, is_primary, sec_rdy, running, pres_o, pres_oe, pres_lvl, al_o, al_oe, al_lvl, sel_n, sel_oe;
   logic [7:0] pattern_index;
   int bad_count = 0, comparisons = 0;
   int n, hi [3];
   // ==========================================================
   // clock, design and far side
   always #10 clk_sys = ~clk_sys;
   pts_trigger_sync uut (.clk_sys(clk_sys), .rst(rst), .pattern_mode(pattern_mode), .pattern_last(pattern_last),
      .expose_cycles(expose_cycles), .colour_select(colour_select), .colour_duty(colour_duty), .sw_start(sw_start),
      .sw_stop(sw_stop), .pattern_advance_in(adv), .pattern_run_in(run), .exposure_active_out(expo),
      .first_pattern_out(first), .red_current_pwm(pwm[0]), .green_current_pwm(pwm[1]), .blue_current_pwm(pwm[2]),
      .red_source_on(src[0]), .green_source_on(src[1]), .blue_source_on(src[2]), .role_strap(role_strap),
      .secondary_present_i(pres_lvl), .secondary_present_o(pres_o), .secondary_present_oe(pres_oe),
      .sequence_align_line_i(al_lvl), .sequence_align_line_o(al_o), .sequence_align_line_oe(al_oe),
      .serial_clk(serial_clk), .serial_cs_req(cs_req), .secondary_port_select_n_o(sel_n),
      .secondary_port_select_n_oe(sel_oe), .is_primary(is_primary), .secondary_ready(sec_rdy), .running(running),
      .pattern_index(pattern_index));
   pts_far_model far (.sec_ready(sec_ready), .present_o(pres_o), .present_oe(pres_oe), .align_o(al_o),
      .align_oe(al_oe), .peer_align_low(peer_al), .present_level(pres_lvl), .align_level(al_lvl));
   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic sw_pulse(input bit stop);
      @(posedge clk_sys);
      if (stop) sw_stop <= 1'b1;
      else sw_start <= 1'b1;
      @(posedge clk_sys);
      {sw_stop, sw_start} <= 2'b00;
      #1;
   endtask
   // bounded wait for the exposure pin level
   task automatic wait_expo(input logic lvl);
      for (int i = 0; i < 40 && expo !== lvl; i++) tk(1);
      chk("exposure", lvl, expo);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_sw_run;
      sw_pulse(0);
      chk("running", 1, running);
      wait_expo(1);
      chk("first", 1, first);
      chk("index", 0, pattern_index);
      chk("sources", 3'b111, src);
      chk("align", 0, al_lvl);
      for (n = 0; n < 40 && expo === 1'b1; n++) tk(1);
      chk("expose_len_ok", 1, n >= 5 && n <= 6);
      hi = '{0, 0, 0};
      repeat (256) begin
         tk(1);
         foreach (hi[c]) hi[c] += pwm[c];
      end
      foreach (hi[c]) chk("pwm_high", 64 * (c + 1), hi[c]);
      $display("test sw_run done");
   endtask
   task automatic t_advance;
      for (int k = 1; k <= 3; k++) begin
         @(posedge clk_sys) adv <= 1'b1;
         repeat (3) @(posedge clk_sys);
         adv <= 1'b0;
         wait_expo(1);
         chk("index", k % 3, pattern_index);
         chk("first", k == 3, first);
         wait_expo(0);
      end
      sw_pulse(1);
      chk("running", 0, running);
      tk(1);
      chk("stopped", 0, {expo, first, src});
      $display("test advance done");
   endtask
   task automatic t_pin_run;
      @(posedge clk_sys) {pattern_mode, run} <= 2'b01;
      tk(8);
      chk("mode_off", 0, running);
      @(posedge clk_sys) {pattern_mode, run} <= 2'b10;
      tk(4);
      @(posedge clk_sys) run <= 1'b1;
      tk(8);
      chk("running", 1, running);
      @(posedge clk_sys) run <= 1'b0;
      tk(8);
      chk("running", 0, running);
      $display("test pin_run done");
   endtask
   task automatic t_select;
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_sys) cs_req <= !v;
         repeat (8) begin
            @(posedge clk_sys) serial_clk <= ~serial_clk;
            repeat (2) @(posedge clk_sys);
         end
         tk(1);
         chk("select_n", v, sel_n);
      end
      $display("test select done");
   endtask
   task automatic t_secondary;
      @(posedge clk_sys) {rst, role_strap, sec_ready} <= 3'b100;
      tk(20);
      @(posedge clk_sys) rst <= 1'b0;
      tk(8);
      chk("roles", 3'b010, {is_primary, pres_lvl, sel_oe});
      @(posedge clk_sys) {run, adv} <= 2'b11;
      tk(10);
      chk("quiet", 0, {running, expo, first, src, pwm});
      @(posedge clk_sys) peer_al <= 1'b1;
      tk(8);
      chk("follow", 1, running);
      chk("dark", 0, {expo, first, src, pwm});
      $display("test secondary done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      tk(20);
      @(posedge clk_sys) rst <= 1'b0;
      tk(1);
      chk("reset_out", 16'h0001, {expo, first, running, src, pwm, sel_n});
      tk(6);
      chk("primary", 3'b110, {is_primary, sec_rdy, pres_oe});
      t_sw_run();
      t_advance();
      t_pin_run();
      t_select();
      t_secondary();
      results();
   end
   initial begin
      #400000;
      bad_count++;
      results();
   end
endmodule
bind pts_trigger_sync pts_trigger_sync_props #(.PAT_W(PAT_W)) props (.clk_sys(clk_sys), .rst(rst),
   .sw_start(sw_start), .sw_stop(sw_stop), .pattern_mode(pattern_mode), .colour_select(colour_select),
   .exposure_active_out(exposure_active_out), .first_pattern_out(first_pattern_out), .red_source_on(red_source_on),
   .green_source_on(green_source_on), .blue_source_on(blue_source_on), .red_current_pwm(red_current_pwm),
   .is_primary(is_primary), .secondary_ready(secondary_ready), .running(running), .pattern_index(pattern_index),
   .secondary_present_oe(secondary_present_oe), .sequence_align_line_oe(sequence_align_line_oe),
   .secondary_port_select_n_oe(secondary_port_select_n_oe));
